// >>> hw/dcpc_pkg.sv
`default_nettype none
package dcpc_pkg;
   // Indexed I/O ports
   localparam logic [15:0] DCPC_INDEX_PORT = 16'h03c4;
   localparam logic [15:0] DCPC_DATA_PORT = 16'h03c5;
   // Register indices
   localparam logic [7:0] DCPC_IDX_TV = 8'h65;
   localparam logic [7:0] DCPC_IDX_PAL = 8'h66;
   localparam logic [7:0] DCPC_IDX_CLK = 8'h68;
   // Reset values
   localparam logic [7:0] DCPC_RST_TV = 8'h00;
   localparam logic [7:0] DCPC_RST_PAL = 8'h00;
   localparam logic [7:0] DCPC_RST_CLK = 8'hc0;
   localparam logic [7:0] DCPC_RST_INDEX = 8'h00;
   localparam logic [7:0] DCPC_READ_ZERO = 8'h00;
   // Writable bits of the TV encoder control register
   localparam logic [7:0] DCPC_TV_WR_MASK = 8'h0f;
   // TV encoder control fields
   localparam int DCPC_TV_PAL_SRC = 3;
   localparam int DCPC_TV_SUBC = 2;
   localparam int DCPC_TV_CLK_SRC = 1;
   localparam int DCPC_TV_SYNC = 0;
   // Palette RAM control fields
   localparam int DCPC_PAL_PWR_HI = 7;
   localparam int DCPC_PAL_PWR_LO = 6;
   localparam int DCPC_PAL_WR_HI = 5;
   localparam int DCPC_PAL_WR_LO = 4;
   localparam int DCPC_PAL_W_HI = 3;
   localparam int DCPC_PAL_W_LO = 2;
   // Clock select fields
   localparam int DCPC_CLK_SEL_HI = 7;
   localparam int DCPC_CLK_SEL_LO = 6;
   localparam int DCPC_CLK_ISO = 5;
   localparam int DCPC_CLK_CHAR = 4;
   localparam int DCPC_CLK_PW_HI = 3;
   localparam int DCPC_CLK_PW_LO = 2;
   localparam int DCPC_CLK_MW_HI = 1;
   localparam int DCPC_CLK_MW_LO = 0;
   // Two-bit field codes
   localparam logic [1:0] DCPC_F00 = 2'h0;
   localparam logic [1:0] DCPC_F01 = 2'h1;
   localparam logic [1:0] DCPC_F10 = 2'h2;
   localparam logic [1:0] DCPC_F11 = 2'h3;
   // Television encoder clock divide ratio
   localparam int DCPC_TV_DIV = 4;
   // Host I/O request
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } dcpc_io_req_t;
   // Pixel clock source and rate
   typedef enum logic [3:0] {
      DCPC_PIX_25180,
      DCPC_PIX_28325,
      DCPC_PIX_31500,
      DCPC_PIX_35484,
      DCPC_PIX_MISC_OTHER,
      DCPC_PIX_SYNTH,
      DCPC_PIX_17734,
      DCPC_PIX_14131,
      DCPC_PIX_PRIMARY
   } dcpc_pix_src_t;
   // Pulse-width trim of the low time in ns
   typedef logic signed [2:0] dcpc_trim_t;
endpackage
`default_nettype wire

// >>> hw/dcpc_top.sv
// Functional notes
// - Three registers sit behind data port 3C5h at indices 65h, 66h, 68h.
// - Reset loads C0h into clock select, 00h into the other two.
// - Palette source bit picks CRT (0) or LCD (1) lookup RAM for reads.
// - Subcarrier mode bit: 0 alternates per field, 1 free-running.
// - TV clock from primary (0) or reference (1) input, divided by four.
// - Sync select drives CRT hsync pin with hsync (0) or composite (1).
// - Palette power: 00 both on, 10 LCD off, 01 CRT off, 11 both off.
// - Palette writes: 00 both, 10 CRT only, 01 LCD only; 11 writes none.
// - Width field 00 six-bit, 10/01/11 eight-bit; low bit set enables gamma.
// - With enable high, select field picks misc, synth, 17.734, 14.131818 MHz.
// - Enable low forces the pixel clock from the primary clock input.
// - ISO bit only matters when the select field is 00.
// - ISO clear: misc 00 gives 25.180 MHz, 01 gives 28.325 MHz.
// - ISO set: misc 00 gives 31.500 MHz, 01 gives 35.484 MHz.
// - Override with LCD or TV forces 8-dot and undivided dot clock.
// - Pixel pulse trim: 00 none, 01 -1 ns, 10 +1 ns, 11 +2 ns.
// - Memory pulse trim: 00 none, 01 -1 ns, 10 +1 ns, 11 +2 ns.
`timescale 1ns/10ps
`default_nettype none
module dcpc_top
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Host indexed I/O
   input wire dcpc_pkg::dcpc_io_req_t IO_REQ,
   output logic [7:0] IO_RDATA,
   output logic IO_RVALID,
   // Clock pins from outside
   input wire logic PRIMARY_CLOCK_INPUT,
   input wire logic REFERENCE_CLOCK_INPUT,
   input wire logic EXTERNAL_CLOCK_ENABLE_N,
   // Sync sources from the CRT timing logic
   input wire logic HSYNC_IN,
   input wire logic COMPOSITE_SYNC_IN,
   // VGA state from other logic
   input wire logic [1:0] MISC_CLOCK_FIELD,
   input wire logic LCD_OR_TV_SELECTED,
   input wire logic CLK_MODE_8DOT,
   input wire logic CLK_MODE_DIV2,
   // Palette write request
   input wire logic PALETTE_WRITE,
   // TV encoder outputs
   output logic CRT_HORIZONTAL_SYNC_PIN,
   output logic TELEVISION_ENCODER_CLOCK,
   output logic SUBCARRIER_FREE_RUN,
   // Palette outputs
   output logic PALETTE_READ_LCD,
   output logic CRT_RAM_POWER,
   output logic LCD_RAM_POWER,
   output logic CRT_RAM_WRITE,
   output logic LCD_RAM_WRITE,
   output logic CRT_PALETTE_8BIT,
   output logic GAMMA_ENABLE,
   // Clock selection outputs
   output dcpc_pkg::dcpc_pix_src_t PIXEL_CLOCK_SOURCE,
   output logic CHAR_CLOCK_8DOT,
   output logic DOT_CLOCK_DIV2,
   output dcpc_pkg::dcpc_trim_t PIXEL_LOW_TRIM,
   output dcpc_pkg::dcpc_trim_t MEMORY_LOW_TRIM
);
   import dcpc_pkg::*;

   logic [7:0] index_reg;
   logic [7:0] tv_reg;
   logic [7:0] pal_reg;
   logic [7:0] clk_reg;
   logic [7:0] rdata_next;
   logic en_n_s1, en_n_s2;
   logic prim_s1, prim_s2, prim_d;
   logic ref_s1, ref_s2, ref_d;
   logic [1:0] tv_edge_cnt_reg;
   logic tv_clk_reg;
   dcpc_pix_src_t pix_next;

   // Port decode
   wire hit_index = IO_REQ.addr == DCPC_INDEX_PORT;
   wire hit_data = IO_REQ.addr == DCPC_DATA_PORT;
   wire wr_index = IO_REQ.wr && hit_index;
   wire wr_tv = IO_REQ.wr && hit_data && index_reg == DCPC_IDX_TV;
   wire wr_pal = IO_REQ.wr && hit_data && index_reg == DCPC_IDX_PAL;
   wire wr_clk = IO_REQ.wr && hit_data && index_reg == DCPC_IDX_CLK;

   // Register fields
   wire [1:0] pal_pwr = pal_reg[DCPC_PAL_PWR_HI:DCPC_PAL_PWR_LO];
   wire [1:0] pal_wr = pal_reg[DCPC_PAL_WR_HI:DCPC_PAL_WR_LO];
   wire [1:0] pal_w = pal_reg[DCPC_PAL_W_HI:DCPC_PAL_W_LO];
   wire [1:0] clk_sel = clk_reg[DCPC_CLK_SEL_HI:DCPC_CLK_SEL_LO];
   wire iso = clk_reg[DCPC_CLK_ISO];
   wire [1:0] pix_pw = clk_reg[DCPC_CLK_PW_HI:DCPC_CLK_PW_LO];
   wire [1:0] mem_pw = clk_reg[DCPC_CLK_MW_HI:DCPC_CLK_MW_LO];
   wire char_ovr = clk_reg[DCPC_CLK_CHAR] && LCD_OR_TV_SELECTED;

   // Edge detect on the synchronised TV clock source
   wire tv_src_rise = tv_reg[DCPC_TV_CLK_SRC] ? (ref_s2 && !ref_d)
                                              : (prim_s2 && !prim_d);
   wire tv_half = tv_edge_cnt_reg == 2'(DCPC_TV_DIV / 2 - 1);

   // Read data selection
   wire [7:0] data_read =
      (index_reg == DCPC_IDX_TV)  ? (tv_reg & DCPC_TV_WR_MASK) :
      (index_reg == DCPC_IDX_PAL) ? pal_reg :
      (index_reg == DCPC_IDX_CLK) ? clk_reg : DCPC_READ_ZERO;
   assign rdata_next = hit_index ? index_reg :
                       hit_data ? data_read : DCPC_READ_ZERO;

   // Low-time trim decode
   function automatic dcpc_trim_t trim_of(input logic [1:0] code);
      dcpc_trim_t t;
      t = 3'sd0;
      case (code)
         DCPC_F01: t = -3'sd1;
         DCPC_F10: t = 3'sd1;
         DCPC_F11: t = 3'sd2;
         default: t = 3'sd0;
      endcase
      return t;
   endfunction

   // Pixel clock source selection
   always_comb
   begin
      pix_next = DCPC_PIX_PRIMARY;
      if (en_n_s2)
      begin
         case (clk_sel)
            DCPC_F00:
            begin
               if (MISC_CLOCK_FIELD == DCPC_F00)
                  pix_next = iso ? DCPC_PIX_31500 : DCPC_PIX_25180;
               else if (MISC_CLOCK_FIELD == DCPC_F01)
                  pix_next = iso ? DCPC_PIX_35484 : DCPC_PIX_28325;
               else
                  pix_next = DCPC_PIX_MISC_OTHER;
            end
            DCPC_F01: pix_next = DCPC_PIX_SYNTH;
            DCPC_F10: pix_next = DCPC_PIX_17734;
            default: pix_next = DCPC_PIX_14131;
         endcase
      end
   end

   // Index and configuration registers
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         index_reg <= DCPC_RST_INDEX;
         tv_reg <= DCPC_RST_TV;
         pal_reg <= DCPC_RST_PAL;
         clk_reg <= DCPC_RST_CLK;
      end
      else
      begin
         if (wr_index)
            index_reg <= IO_REQ.wdata;
         if (wr_tv)
            tv_reg <= IO_REQ.wdata & DCPC_TV_WR_MASK;
         if (wr_pal)
            pal_reg <= IO_REQ.wdata;
         if (wr_clk)
            clk_reg <= IO_REQ.wdata;
      end
   end

   // Host read data
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         IO_RDATA <= DCPC_READ_ZERO;
         IO_RVALID <= 1'b0;
      end
      else
      begin
         IO_RVALID <= IO_REQ.rd && (hit_index || hit_data);
         if (IO_REQ.rd)
            IO_RDATA <= rdata_next;
      end
   end

   // Pin synchronisers
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         {en_n_s1, en_n_s2} <= 2'b00;
         {prim_s1, prim_s2, prim_d} <= 3'b000;
         {ref_s1, ref_s2, ref_d} <= 3'b000;
      end
      else
      begin
         en_n_s1 <= EXTERNAL_CLOCK_ENABLE_N;
         en_n_s2 <= en_n_s1;
         prim_s1 <= PRIMARY_CLOCK_INPUT;
         prim_s2 <= prim_s1;
         prim_d <= prim_s2;
         ref_s1 <= REFERENCE_CLOCK_INPUT;
         ref_s2 <= ref_s1;
         ref_d <= ref_s2;
      end
   end

   // Television encoder clock divider
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         tv_edge_cnt_reg <= 2'h0;
         tv_clk_reg <= 1'b0;
      end
      else if (tv_src_rise)
      begin
         tv_edge_cnt_reg <= tv_half ? 2'h0 : tv_edge_cnt_reg + 2'h1;
         if (tv_half)
            tv_clk_reg <= !tv_clk_reg;
      end
   end

   // Registered control outputs
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         CRT_HORIZONTAL_SYNC_PIN <= 1'b0;
         SUBCARRIER_FREE_RUN <= 1'b0;
         PALETTE_READ_LCD <= 1'b0;
         CRT_RAM_POWER <= 1'b1;
         LCD_RAM_POWER <= 1'b1;
         CRT_RAM_WRITE <= 1'b0;
         LCD_RAM_WRITE <= 1'b0;
         CRT_PALETTE_8BIT <= 1'b0;
         GAMMA_ENABLE <= 1'b0;
         PIXEL_CLOCK_SOURCE <= DCPC_PIX_PRIMARY;
         CHAR_CLOCK_8DOT <= 1'b0;
         DOT_CLOCK_DIV2 <= 1'b0;
         PIXEL_LOW_TRIM <= 3'sd0;
         MEMORY_LOW_TRIM <= 3'sd0;
      end
      else
      begin
         CRT_HORIZONTAL_SYNC_PIN <= tv_reg[DCPC_TV_SYNC] ?
            COMPOSITE_SYNC_IN : HSYNC_IN;
         SUBCARRIER_FREE_RUN <= tv_reg[DCPC_TV_SUBC];
         PALETTE_READ_LCD <= tv_reg[DCPC_TV_PAL_SRC];
         CRT_RAM_POWER <= !pal_pwr[0];
         LCD_RAM_POWER <= !pal_pwr[1];
         CRT_RAM_WRITE <= PALETTE_WRITE && !pal_wr[0];
         LCD_RAM_WRITE <= PALETTE_WRITE && !pal_wr[1];
         CRT_PALETTE_8BIT <= pal_w != DCPC_F00;
         GAMMA_ENABLE <= pal_w[0];
         PIXEL_CLOCK_SOURCE <= pix_next;
         CHAR_CLOCK_8DOT <= char_ovr || CLK_MODE_8DOT;
         DOT_CLOCK_DIV2 <= !char_ovr && CLK_MODE_DIV2;
         PIXEL_LOW_TRIM <= trim_of(pix_pw);
         MEMORY_LOW_TRIM <= trim_of(mem_pw);
      end
   end

   assign TELEVISION_ENCODER_CLOCK = tv_clk_reg;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_tv_write;
      wr_tv ##4 (index_reg == DCPC_IDX_TV && IO_REQ.rd && hit_data)
         |=> IO_RDATA == ($past(IO_REQ.wdata, 5) & DCPC_TV_WR_MASK);
   endproperty
   a_tv_write: assert property (p_tv_write)
      else $error("TV register readback wrong");

   property p_tv_reserved;
      IO_RVALID && $past(index_reg) == DCPC_IDX_TV && $past(hit_data)
         |-> IO_RDATA[7:4] == 4'h0;
   endproperty
   a_tv_reserved: assert property (p_tv_reserved)
      else $error("TV reserved bits not zero");

   property p_sync;
      ##1 $past(tv_reg[DCPC_TV_SYNC]) |-> CRT_HORIZONTAL_SYNC_PIN
         == $past(COMPOSITE_SYNC_IN);
   endproperty
   a_sync: assert property (p_sync)
      else $error("Composite sync not routed");

   sequence s_en_low;
      !EXTERNAL_CLOCK_ENABLE_N [*3];
   endsequence
   property p_primary;
      s_en_low |=> PIXEL_CLOCK_SOURCE == DCPC_PIX_PRIMARY;
   endproperty
   a_primary: assert property (p_primary)
      else $error("Pixel clock not from primary input");

   property p_iso;
      en_n_s2 && clk_sel == DCPC_F00 && MISC_CLOCK_FIELD == DCPC_F00
         |=> PIXEL_CLOCK_SOURCE == ($past(iso) ? DCPC_PIX_31500
                                               : DCPC_PIX_25180);
   endproperty
   a_iso: assert property (p_iso)
      else $error("VGA pixel rate wrong");

   property p_pal_reserved;
      pal_wr == DCPC_F11 |=> !CRT_RAM_WRITE && !LCD_RAM_WRITE;
   endproperty
   a_pal_reserved: assert property (p_pal_reserved)
      else $error("Palette write under reserved code");

   property p_power;
      pal_pwr == DCPC_F11 |=> !CRT_RAM_POWER && !LCD_RAM_POWER;
   endproperty
   a_power: assert property (p_power)
      else $error("Palette RAM power wrong");

   property p_trim;
      clk_reg[DCPC_CLK_MW_HI:DCPC_CLK_MW_LO] == DCPC_F11
         |=> MEMORY_LOW_TRIM == 3'sd2;
   endproperty
   a_trim: assert property (p_trim)
      else $error("Memory trim wrong");

   property p_override;
      char_ovr |=> CHAR_CLOCK_8DOT && !DOT_CLOCK_DIV2;
   endproperty
   a_override: assert property (p_override)
      else $error("Character clock override ignored");

   property p_tv_div;
      !tv_src_rise |=> $stable(tv_clk_reg);
   endproperty
   a_tv_div: assert property (p_tv_div)
      else $error("TV clock toggled without source edge");
endmodule // dcpc_top
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import dcpc_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   dcpc_io_req_t io_req = '0;
   logic pri = 1'b0, refc = 1'b0, ext_n = 1'b1, hs = 1'b0, cs = 1'b0;
   logic [1:0] misc = 2'h0;
   logic lcdtv = 1'b0, m8 = 1'b0, d2 = 1'b0, pal_wr = 1'b0;
   logic [7:0] rdata;
   logic rvalid, crt_hs, tv_clk, subc, rd_lcd, crt_pwr, lcd_pwr;
   logic crt_wr, lcd_wr, pal8, gamma, ch8, div2;
   dcpc_pix_src_t pix;
   dcpc_trim_t ptrim, mtrim;
   int failures = 0;
   int checks = 0;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'hc0fa;
   logic [2:0] trim_tab[4] = '{3'h0, 3'h7, 3'h1, 3'h2};

   // Clock
   always #20 CLK = ~CLK;

   dcpc_top uut (.CLK(CLK), .RST(RST), .IO_REQ(io_req), .IO_RDATA(rdata),
      .IO_RVALID(rvalid), .PRIMARY_CLOCK_INPUT(pri),
      .REFERENCE_CLOCK_INPUT(refc), .EXTERNAL_CLOCK_ENABLE_N(ext_n),
      .HSYNC_IN(hs), .COMPOSITE_SYNC_IN(cs), .MISC_CLOCK_FIELD(misc),
      .LCD_OR_TV_SELECTED(lcdtv), .CLK_MODE_8DOT(m8), .CLK_MODE_DIV2(d2),
      .PALETTE_WRITE(pal_wr), .CRT_HORIZONTAL_SYNC_PIN(crt_hs),
      .TELEVISION_ENCODER_CLOCK(tv_clk), .SUBCARRIER_FREE_RUN(subc),
      .PALETTE_READ_LCD(rd_lcd), .CRT_RAM_POWER(crt_pwr),
      .LCD_RAM_POWER(lcd_pwr), .CRT_RAM_WRITE(crt_wr),
      .LCD_RAM_WRITE(lcd_wr), .CRT_PALETTE_8BIT(pal8), .GAMMA_ENABLE(gamma),
      .PIXEL_CLOCK_SOURCE(pix), .CHAR_CLOCK_8DOT(ch8),
      .DOT_CLOCK_DIV2(div2), .PIXEL_LOW_TRIM(ptrim),
      .MEMORY_LOW_TRIM(mtrim));

   // Comparison and verdict helpers
   task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic final_report;
      if (exp_q.size() != 0)
      begin
         failures++;
         $display("CHECK FAILED read notes expected 0 seen %0d", exp_q.size());
      end
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Bus cycles, one strobe cycle then one idle cycle
   task automatic io(input logic [15:0] a, input logic w, input logic r,
      input logic [7:0] d);
      io_req = '{addr: a, wr: w, rd: r, wdata: d};
      @(negedge CLK);
      io_req = '0;
      @(negedge CLK);
   endtask

   task automatic wreg(input logic [7:0] i, input logic [7:0] d);
      io(DCPC_INDEX_PORT, 1'b1, 1'b0, i);
      io(DCPC_DATA_PORT, 1'b1, 1'b0, d);
   endtask

   task automatic rreg(input logic [7:0] i, input logic [7:0] e);
      io(DCPC_INDEX_PORT, 1'b1, 1'b0, i);
      exp_q.push_back(e);
      io(DCPC_DATA_PORT, 1'b0, 1'b1, 8'h00);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask

   function automatic void rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
   endfunction

   // Expected pixel clock choice with the enable pin inactive
   function automatic dcpc_pix_src_t pix_exp(input logic [1:0] s,
      input logic iso, input logic [1:0] m);
      if (s == DCPC_F01)
         return DCPC_PIX_SYNTH;
      if (s == DCPC_F10)
         return DCPC_PIX_17734;
      if (s == DCPC_F11)
         return DCPC_PIX_14131;
      if (m == DCPC_F00)
         return iso ? DCPC_PIX_31500 : DCPC_PIX_25180;
      if (m == DCPC_F01)
         return iso ? DCPC_PIX_35484 : DCPC_PIX_28325;
      return DCPC_PIX_MISC_OTHER;
   endfunction

   // Read answers are matched against the oldest note
   always @(negedge CLK)
      if (rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            failures++;
            $display("CHECK FAILED read note expected 1 seen 0");
         end
         else
            chk("read data", exp_q.pop_front(), rdata);
      end

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge CLK);
      failures++;
      $display("CHECK FAILED watchdog expected 0 seen 1");
      final_report();
   end

   // Main sequence
   initial
   begin
      logic [7:0] v;
      logic [7:0] nc, nl, n;
      logic prev;
      cyc(10);
      RST = 1'b0;
      cyc(5);
      chk("pixel source", {4'h0, DCPC_PIX_14131}, {4'h0, pix});
      chk("ram power", 8'h03, {6'h0, crt_pwr, lcd_pwr});
      rreg(DCPC_IDX_TV, DCPC_RST_TV);
      rreg(DCPC_IDX_PAL, DCPC_RST_PAL);
      rreg(DCPC_IDX_CLK, DCPC_RST_CLK);
      // TV encoder control bits with random data
      for (int i = 0; i < 6; i++)
      begin
         rnd();
         v = {seed[7:1], i[0]};
         hs = seed[8];
         cs = seed[9];
         wreg(DCPC_IDX_TV, v);
         chk("sync pin", {7'h0, v[0] ? cs : hs}, {7'h0, crt_hs});
         chk("subcarrier", {7'h0, v[2]}, {7'h0, subc});
         chk("palette read", {7'h0, v[3]}, {7'h0, rd_lcd});
         rreg(DCPC_IDX_TV, v & DCPC_TV_WR_MASK);
      end
      // Palette power, steering and width codes
      for (int c = 0; c < 4; c++)
      begin
         wreg(DCPC_IDX_PAL, {c[1:0], c[1:0], c[1:0], 2'h0});
         chk("crt power", {7'h0, ~c[0]}, {7'h0, crt_pwr});
         chk("lcd power", {7'h0, ~c[1]}, {7'h0, lcd_pwr});
         chk("width", {7'h0, c != 0}, {7'h0, pal8});
         chk("gamma", {7'h0, c[0]}, {7'h0, gamma});
         pal_wr = 1'b1;
         nc = 0;
         nl = 0;
         repeat (4)
         begin
            @(negedge CLK);
            pal_wr = 1'b0;
            nc += crt_wr;
            nl += lcd_wr;
         end
         chk("crt writes", {7'h0, ~c[0]}, nc[7:0]);
         chk("lcd writes", {7'h0, ~c[1]}, nl[7:0]);
      end
      // Pixel clock choice, ISO rates and trims
      for (int k = 0; k < 32; k++)
      begin
         rnd();
         misc = k[1:0];
         wreg(DCPC_IDX_CLK, {k[4:3], k[2], 1'b0, seed[3:0]});
         chk("pixel source", {4'h0, pix_exp(k[4:3], k[2], k[1:0])},
            {4'h0, pix});
         chk("pixel trim", {5'h0, trim_tab[seed[3:2]]}, {5'h0, ptrim});
         chk("memory trim", {5'h0, trim_tab[seed[1:0]]}, {5'h0, mtrim});
      end
      ext_n = 1'b0;
      cyc(5);
      chk("pixel source", {4'h0, DCPC_PIX_PRIMARY}, {4'h0, pix});
      ext_n = 1'b1;
      // Character clock override
      for (int i = 0; i < 4; i++)
      begin
         rnd();
         lcdtv = i[0];
         m8 = seed[0];
         d2 = seed[1];
         wreg(DCPC_IDX_CLK, {3'h6, i[1], 4'h0});
         chk("char 8dot", {7'h0, (i == 3) | m8}, {7'h0, ch8});
         chk("dot div2", {7'h0, (i != 3) & d2}, {7'h0, div2});
      end
      // TV clock from the chosen pin, the other pin runs twice as fast
      for (int s = 0; s < 2; s++)
      begin
         wreg(DCPC_IDX_TV, {6'h0, s[0], 1'b0});
         n = 0;
         prev = tv_clk;
         for (int k = 0; k < 256; k++)
         begin
            @(negedge CLK);
            pri ^= (k % (s ? 2 : 4) == 0);
            refc ^= (k % (s ? 4 : 2) == 0);
            n += (tv_clk !== prev);
            prev = tv_clk;
         end
         chk("tv toggles", 8'd16, (n >= 15 && n <= 17) ? 8'd16 : n[7:0]);
      end
      // Unmapped index and address are ignored
      wreg(8'h67, 8'hff);
      rreg(8'h67, DCPC_READ_ZERO);
      io(DCPC_INDEX_PORT, 1'b1, 1'b0, DCPC_IDX_CLK);
      io(16'h03c6, 1'b1, 1'b0, 8'h00);
      io(16'h03c6, 1'b0, 1'b1, 8'h00);
      rreg(DCPC_IDX_CLK, 8'hd0);
      cyc(4);
      final_report();
   end
endmodule // testbench
`default_nettype wire
